/* tgp_pkg.sv */
// constants for the tone generator and charge pump control block
package tgp_pkg;
  // byte register indices on the serial setup port
  localparam logic [2:0] TGP_ADDR_POWER = 3'h0;
  localparam logic [2:0] TGP_ADDR_COEF_LOW = 3'h4;
  localparam logic [2:0] TGP_ADDR_COEF_HIGH = 3'h5;
  localparam logic [2:0] TGP_ADDR_TONE = 3'h7;
  // field positions
  localparam int TGP_TONE_FIRST_BIT = 0;
  localparam int TGP_TONE_SECOND_BIT = 1;
  localparam int TGP_TONE_ON_BIT = 3;
  localparam int TGP_TONE_PEND_BIT = 7;
  localparam int TGP_PUMP_OFF_BIT = 2;
  localparam int TGP_COEF_SEL_LSB = 6;
  // setup port frame: read flag, address, data, msb first
  localparam int TGP_FRAME_BITS = 16;
  localparam logic [4:0] TGP_ADDR_DONE_CNT = 5'h0_007;
  localparam logic [4:0] TGP_LAST_CNT = 5'h0_00F;
  localparam logic [4:0] TGP_END_CNT = 5'h0_010;
  // transmit release after enable rises, least allowed longest delay
  localparam int TGP_TX_RELEASE_NS = 140;
  localparam int TGP_LINK_PERIOD_NS = 30;
  // tone engine number formats
  localparam int TGP_COEF_W = 12;
  localparam int TGP_COEF_FRAC = 11;
  localparam int TGP_OSC_W = 16;
  localparam logic signed [15:0] TGP_OSC_ONE = 16'sh4000; // 1.0 with 14 fraction bits
  localparam logic [7:0] TGP_RESET_BYTE = 8'h00;
endpackage : tgp_pkg

/* tgp_tone_pump_ctrl.sv */
// tone generator, decoder displacement and charge pump control behind the setup port
`timescale 1ns/1ns
module tgp_tone_pump_ctrl (
  input wire logic clk_i, // core clock, 100 MHz
  input wire logic reset_i, // synchronous reset, active high
  input wire logic setup_port_clk_i, // setup port clock from the host
  input wire logic setup_port_enable_n_i, // setup port enable, frame while low
  input wire logic setup_port_receive_i, // serial data from the host
  output logic setup_port_transmit_o, // serial read data to the host
  output logic setup_port_transmit_oe_o, // high while transmit is driven
  input wire logic receive_frame_sync_i, // receive frame sync pin
  input wire logic signed [15:0] decoded_sample_i, // decoder sample, core clock
  input wire logic decoded_valid_i, // decoder sample strobe
  output logic decoder_enable_o, // decoder run enable
  output logic charge_pump_run_o, // charge pump run
  output logic first_tone_oscillator_o, // first oscillator active
  output logic second_tone_oscillator_o, // second oscillator active
  output logic signed [15:0] output_sample_o, // sample to the output path
  output logic output_valid_o // output sample strobe
);
  import tgp_pkg::*;

  localparam int TxReleaseCycles = TGP_TX_RELEASE_NS / TGP_LINK_PERIOD_NS;
  if (TxReleaseCycles < 1) begin : g_chk
    $error("transmit release budget below one link cycle");
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: frame shifter on the setup port clock
  logic [4:0] lk_cnt_q, lk_cnt_d;
  logic [15:0] lk_sh_q, lk_sh_d;
  logic [7:0] lk_rd_q, lk_rd_d;
  logic lk_tx_q, lk_tx_d, lk_oe_q, lk_oe_d;
  logic [15:0] lk_word_q = 16'h0000;
  logic [15:0] lk_word_d;
  logic lk_tog_q = 1'b0;
  logic lk_tog_d;
  logic [7:0] snap_q [8];
  logic [15:0] lk_full;

  // next state of the shifter and read out path
  always_comb begin
    lk_full = {lk_sh_q[14:0], setup_port_receive_i};
    lk_cnt_d = (lk_cnt_q == TGP_END_CNT) ? lk_cnt_q : lk_cnt_q + 5'h0_001;
    lk_sh_d = lk_full;
    lk_rd_d = {lk_rd_q[6:0], 1'b0};
    lk_tx_d = lk_rd_q[7];
    lk_oe_d = lk_oe_q;
    lk_word_d = lk_word_q;
    lk_tog_d = lk_tog_q;
    if (lk_cnt_q == TGP_ADDR_DONE_CNT && lk_full[7]) begin
      // read request: snapshot is frozen by the core during the frame
      lk_rd_d = {snap_q[lk_full[2:0]][6:0], 1'b0};
      lk_tx_d = snap_q[lk_full[2:0]][7];
      lk_oe_d = 1'b1;
    end
    if (lk_cnt_q == TGP_LAST_CNT && !lk_full[15]) begin
      lk_word_d = lk_full;
      lk_tog_d = ~lk_tog_q;
    end
  end

  // frame state, cleared by the enable itself since the clock stops between frames
  always_ff @(posedge setup_port_clk_i or posedge setup_port_enable_n_i) begin
    if (setup_port_enable_n_i) begin
      lk_cnt_q <= 5'h0_000;
      lk_sh_q <= 16'h0000;
      lk_rd_q <= TGP_RESET_BYTE;
      lk_tx_q <= 1'b0;
      lk_oe_q <= 1'b0;
    end else begin
      lk_cnt_q <= lk_cnt_d;
      lk_sh_q <= lk_sh_d;
      lk_rd_q <= lk_rd_d;
      lk_tx_q <= lk_tx_d;
      lk_oe_q <= lk_oe_d;
    end
  end

  // write word and its toggle survive the end of the frame
  always_ff @(posedge setup_port_clk_i) begin
    lk_word_q <= lk_word_d;
    lk_tog_q <= lk_tog_d;
  end

  assign setup_port_transmit_o = lk_tx_q;
  assign setup_port_transmit_oe_o = lk_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // core domain: synchronisers
  logic [2:0] tg_s_q, tg_s_d;
  logic [2:0] fs_s_q, fs_s_d;
  logic [1:0] en_s_q, en_s_d;
  logic wr_evt, fs_evt;

  always_comb begin
    tg_s_d = {tg_s_q[1:0], lk_tog_q};
    fs_s_d = {fs_s_q[1:0], receive_frame_sync_i};
    en_s_d = {en_s_q[0], setup_port_enable_n_i};
    wr_evt = tg_s_q[2] ^ tg_s_q[1];
    fs_evt = fs_s_q[1] & ~fs_s_q[2];
  end

  always_ff @(posedge clk_i) begin
    tg_s_q <= tg_s_d;
    fs_s_q <= fs_s_d;
    en_s_q <= en_s_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // core domain: control bytes, pending flag and coefficient slots
  logic [7:0] pwr_q, pwr_d, tone_q, tone_d, clo_q, clo_d, chi_q, chi_d;
  logic pend_q, pend_d;
  logic signed [11:0] coef_q [4];
  logic signed [11:0] coef_d [4];
  logic [2:0] wr_addr;
  logic [7:0] wr_data;

  always_comb begin
    wr_addr = lk_word_q[10:8];
    wr_data = lk_word_q[7:0];
    pwr_d = pwr_q;
    tone_d = tone_q;
    clo_d = clo_q;
    chi_d = chi_q;
    pend_d = pend_q;
    coef_d = coef_q;
    if (fs_evt && pend_q) begin
      // one coefficient transfer per receive frame
      coef_d[chi_q[TGP_COEF_SEL_LSB +: 2]] = {chi_q[3:0], clo_q};
      pend_d = 1'b0;
    end
    if (wr_evt) begin
      case (wr_addr)
        TGP_ADDR_POWER: pwr_d = wr_data;
        TGP_ADDR_TONE: tone_d = {4'h0, wr_data[3:0]};
        TGP_ADDR_COEF_LOW: clo_d = wr_data;
        TGP_ADDR_COEF_HIGH: begin
          chi_d = wr_data;
          pend_d = 1'b1;
        end
        default: pend_d = pend_d;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwr_q <= TGP_RESET_BYTE;
      tone_q <= TGP_RESET_BYTE;
      clo_q <= TGP_RESET_BYTE;
      chi_q <= TGP_RESET_BYTE;
      pend_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        coef_q[i] <= 12'sh000;
      end
    end else begin
      pwr_q <= pwr_d;
      tone_q <= tone_d;
      clo_q <= clo_d;
      chi_q <= chi_d;
      pend_q <= pend_d;
      coef_q <= coef_d;
    end
  end

  // read snapshot, refreshed only between frames
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 8; i++) begin
        snap_q[i] <= TGP_RESET_BYTE;
      end
    end else if (en_s_q[1]) begin
      for (int i = 0; i < 8; i++) begin
        snap_q[i] <= TGP_RESET_BYTE;
      end
      snap_q[TGP_ADDR_POWER] <= pwr_q;
      snap_q[TGP_ADDR_COEF_LOW] <= clo_q;
      snap_q[TGP_ADDR_COEF_HIGH] <= chi_q;
      snap_q[TGP_ADDR_TONE] <= {pend_q, tone_q[6:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tone engine: one recurrence per oscillator, stepped per receive frame
  logic tone_on;
  logic [1:0] osc_en;
  logic signed [15:0] osc_out [2];
  logic signed [16:0] tone_sum;

  assign tone_on = tone_q[TGP_TONE_ON_BIT];
  assign osc_en = {tone_q[TGP_TONE_SECOND_BIT], tone_q[TGP_TONE_FIRST_BIT]};

  for (genvar g = 0; g < 2; g++) begin : g_osc
    logic signed [15:0] cur_q, cur_d, prv_q, prv_d, amp_q, amp_d;
    logic signed [27:0] prod;
    logic signed [27:0] aprod;
    logic signed [11:0] fcoef, acoef;
    always_comb begin
      fcoef = coef_q[2 * g];
      acoef = coef_q[2 * g + 1];
      prod = fcoef * cur_q;
      aprod = acoef * cur_q;
      cur_d = cur_q;
      prv_d = prv_q;
      amp_d = amp_q;
      if (!(tone_on && osc_en[g])) begin
        // seed y(0)=1 and y(-1)=c so the sequence is cos(n*w)
        cur_d = TGP_OSC_ONE;
        prv_d = 16'(fcoef) <<< 3;
        amp_d = 16'sh0000;
      end else if (fs_evt) begin
        cur_d = 16'((prod >>> (TGP_COEF_FRAC - 1)) - 28'(prv_q));
        prv_d = cur_q;
        amp_d = 16'(aprod >>> TGP_COEF_FRAC);
      end
    end
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        cur_q <= TGP_OSC_ONE;
        prv_q <= 16'sh0000;
        amp_q <= 16'sh0000;
      end else begin
        cur_q <= cur_d;
        prv_q <= prv_d;
        amp_q <= amp_d;
      end
    end
    assign osc_out[g] = amp_q;
  end

  assign tone_sum = 17'(osc_out[0]) + 17'(osc_out[1]);

  //////////////////////////////////////////////////////////////////////////////
  // output path and status outputs
  logic dec_en_q, dec_en_d, pump_q, pump_d, o1_q, o1_d, o2_q, o2_d, ov_q, ov_d, tv_q, tv_d;
  logic signed [15:0] os_q, os_d;

  always_comb begin
    dec_en_d = ~tone_on;
    pump_d = ~pwr_q[TGP_PUMP_OFF_BIT];
    o1_d = tone_on & osc_en[0];
    o2_d = tone_on & osc_en[1];
    tv_d = fs_evt & tone_on;
    os_d = os_q;
    ov_d = 1'b0;
    if (tone_on) begin
      // one core cycle late so the engine has stepped
      ov_d = tv_q;
      if (tv_q) begin
        os_d = 16'(tone_sum >>> 1);
      end
    end else if (decoded_valid_i) begin
      os_d = decoded_sample_i;
      ov_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dec_en_q <= 1'b1;
      pump_q <= 1'b1;
      o1_q <= 1'b0;
      o2_q <= 1'b0;
      ov_q <= 1'b0;
      tv_q <= 1'b0;
      os_q <= 16'sh0000;
    end else begin
      dec_en_q <= dec_en_d;
      pump_q <= pump_d;
      o1_q <= o1_d;
      o2_q <= o2_d;
      ov_q <= ov_d;
      tv_q <= tv_d;
      os_q <= os_d;
    end
  end

  assign decoder_enable_o = dec_en_q;
  assign charge_pump_run_o = pump_q;
  assign first_tone_oscillator_o = o1_q;
  assign second_tone_oscillator_o = o2_q;
  assign output_sample_o = os_q;
  assign output_valid_o = ov_q;
endmodule // tgp_tone_pump_ctrl

/* tgp_tone_pump_ctrl_sva.sv */
// port checks for the tone and pump control block
`timescale 1ns/1ns
module tgp_tone_pump_ctrl_sva (
  input wire logic clk_i, // core clock
  input wire logic reset_i, // sync reset
  input wire logic setup_port_enable_n_i, // frame enable
  input wire logic setup_port_transmit_oe_o, // tx drive
  input wire logic receive_frame_sync_i, // frame sync
  input wire logic signed [15:0] decoded_sample_i, // decoder sample
  input wire logic decoded_valid_i, // sample strobe
  input wire logic decoder_enable_o, // decoder run
  input wire logic charge_pump_run_o, // pump run
  input wire logic first_tone_oscillator_o, // osc one
  input wire logic second_tone_oscillator_o, // osc two
  input wire logic signed [15:0] output_sample_o, // out sample
  input wire logic output_valid_o // out strobe
);
  logic [4:0] idle_q, idle_d;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // cycles since the enable was last low, saturating
  always_comb begin
    idle_d = idle_q;
    if (reset_i || (idle_q != 5'h1f && setup_port_enable_n_i)) begin
      idle_d = reset_i ? 5'h1f : idle_q + 5'h01;
    end else if (!setup_port_enable_n_i) begin
      idle_d = 5'h00;
    end
  end
  always_ff @(posedge clk_i) begin
    idle_q <= idle_d;
  end
  sequence s_sync_edge;
    $rose(receive_frame_sync_i) ##0 first_tone_oscillator_o;
  endsequence
  property p_reset;
    @(posedge clk_i) disable iff (1'b0) reset_i |=> charge_pump_run_o && decoder_enable_o;
  endproperty
  property p_release;
    setup_port_enable_n_i |-> !setup_port_transmit_oe_o;
  endproperty
  property p_osc_tone;
    $rose(first_tone_oscillator_o | second_tone_oscillator_o) |-> ##[0:2] !decoder_enable_o;
  endproperty
  property p_no_osc;
    decoder_enable_o [*3] |-> !first_tone_oscillator_o && !second_tone_oscillator_o;
  endproperty
  property p_pass;
    decoder_enable_o && decoded_valid_i |=>
      output_valid_o && output_sample_o == $past(decoded_sample_i);
  endproperty
  property p_one_pulse;
    output_valid_o && !decoder_enable_o |=> !output_valid_o;
  endproperty
  property p_by_write;
    $changed({charge_pump_run_o, decoder_enable_o}) |-> idle_q < 5'h10;
  endproperty
  property p_tone_sample;
    s_sync_edge |-> ##[2:8] output_valid_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset outputs");
  a_release: assert property (p_release) else $error("tx still driven");
  a_osc_tone: assert property (p_osc_tone) else $error("osc without tone");
  a_no_osc: assert property (p_no_osc) else $error("osc with decoder");
  a_pass: assert property (p_pass) else $error("sample not passed");
  a_one_pulse: assert property (p_one_pulse) else $error("long tone strobe");
  a_by_write: assert property (p_by_write) else $error("change without write");
  a_tone_sample: assert property (p_tone_sample) else $error("no tone sample");
endmodule // tgp_tone_pump_ctrl_sva
bind tgp_tone_pump_ctrl tgp_tone_pump_ctrl_sva tgp_tone_pump_ctrl_sva_i (
  .clk_i, .reset_i, .setup_port_enable_n_i, .setup_port_transmit_oe_o, .receive_frame_sync_i,
  .decoded_sample_i, .decoded_valid_i, .decoder_enable_o, .charge_pump_run_o,
  .first_tone_oscillator_o, .second_tone_oscillator_o, .output_sample_o, .output_valid_o
);

/* tgp_host_model.sv */
// host model driving the serial setup port
`timescale 1ns/1ns
module tgp_host_model (
  output logic sck_o, // link clock
  output logic enable_n_o, // frame enable
  output logic rx_o, // data out
  input wire logic tx_i // read data in
);
  // link idle: clock still, enable high
  initial begin
    sck_o = 1'b0;
    enable_n_o = 1'b1;
    rx_o = 1'b0;
  end
  // one frame: read flag, index, data, msb first
  task automatic xfer(input logic rd, input logic [2:0] idx, input logic [7:0] wd,
                      output logic [7:0] rdata);
    logic [15:0] w;
    w = {rd, 4'h0, idx, wd};
    rdata = 8'h00;
    enable_n_o = 1'b0;
    #60;
    for (int i = 15; i >= 0; i--) begin
      rx_o = w[i];
      #15;
      sck_o = 1'b1;
      #15;
      sck_o = 1'b0;
      if (i >= 1 && i <= 8) begin
        rdata = {rdata[6:0], tx_i};
      end
    end
    #60;
    enable_n_o = 1'b1;
    rx_o = ~rx_o; // released line shows no stale value
    #200;
  endtask
endmodule // tgp_host_model

/* tgp_tone_pump_ctrl_tb.sv */
// self-checking bench for the tone and pump control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); \
  end \
end
module tgp_tone_pump_ctrl_tb;
  import tgp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic setup_port_clk_i, setup_port_enable_n_i, setup_port_receive_i, setup_port_transmit_o;
  logic setup_port_transmit_oe_o, decoder_enable_o, charge_pump_run_o, output_valid_o;
  logic first_tone_oscillator_o, second_tone_oscillator_o;
  logic receive_frame_sync_i = 1'b0;
  logic decoded_valid_i = 1'b0;
  logic signed [15:0] decoded_sample_i = 16'sh0000;
  logic signed [15:0] output_sample_o;
  logic [7:0] rd;
  int n_mismatch = 0;
  int checks_done = 0;
  // core clock
  always #5 clk_i = ~clk_i;
  tgp_tone_pump_ctrl tgp_tone_pump_ctrl_i (
    .clk_i, .reset_i, .setup_port_clk_i, .setup_port_enable_n_i, .setup_port_receive_i,
    .setup_port_transmit_o, .setup_port_transmit_oe_o, .receive_frame_sync_i,
    .decoded_sample_i, .decoded_valid_i, .decoder_enable_o, .charge_pump_run_o,
    .first_tone_oscillator_o, .second_tone_oscillator_o, .output_sample_o, .output_valid_o
  );
  tgp_host_model tgp_host_model_i (
    .sck_o(setup_port_clk_i), .enable_n_o(setup_port_enable_n_i),
    .rx_o(setup_port_receive_i), .tx_i(setup_port_transmit_o)
  );
  // register access through the host model
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    tgp_host_model_i.xfer(1'b0, a, d, r);
  endtask
  task automatic rdb(input logic [2:0] a);
    tgp_host_model_i.xfer(1'b1, a, 8'h00, rd);
    `CHK("tx release", 1'b0, setup_port_transmit_oe_o)
  endtask
  // one frame sync event plus settling
  task automatic pulse_sync;
    @(negedge clk_i) receive_frame_sync_i = 1'b1;
    repeat (3) @(negedge clk_i);
    receive_frame_sync_i = 1'b0;
  endtask
  task automatic t_pump;
    `CHK("pump reset", 1'b1, charge_pump_run_o)
    wr(TGP_ADDR_POWER, 8'h04);
    `CHK("pump off", 1'b0, charge_pump_run_o)
    rdb(TGP_ADDR_POWER);
    `CHK("power byte", 8'h04, rd)
    wr(TGP_ADDR_POWER, 8'hfb);
    `CHK("pump on", 1'b1, charge_pump_run_o)
    rdb(3'h2);
    `CHK("unmapped", 8'h00, rd)
    $display("test pump done");
  endtask
  task automatic t_pass;
    @(negedge clk_i) decoded_sample_i = 16'sh1234;
    decoded_valid_i = 1'b1;
    @(negedge clk_i) decoded_valid_i = 1'b0;
    `CHK("pass sample", 16'sh1234, output_sample_o)
    `CHK("pass valid", 1'b1, output_valid_o)
    $display("test pass done");
  endtask
  task automatic t_coef;
    logic [11:0] cf [2] = '{12'h4a8, 12'h18c};
    for (int s = 0; s < 2; s++) begin
      wr(TGP_ADDR_COEF_LOW, cf[s][7:0]);
      wr(TGP_ADDR_COEF_HIGH, {s[1:0], 2'b00, cf[s][11:8]});
      rdb(TGP_ADDR_TONE);
      `CHK("pending", 1'b1, rd[TGP_TONE_PEND_BIT])
      pulse_sync;
      rdb(TGP_ADDR_TONE);
      `CHK("pending clear", 1'b0, rd[TGP_TONE_PEND_BIT])
    end
    $display("test coef done");
  endtask
  task automatic t_tone;
    int seen;
    wr(TGP_ADDR_TONE, 8'h08); // select bits held at zero
    `CHK("decoder off", 1'b0, decoder_enable_o)
    @(negedge clk_i) decoded_valid_i = 1'b1;
    @(negedge clk_i) decoded_valid_i = 1'b0;
    `CHK("dropped", 1'b0, output_valid_o)
    wr(TGP_ADDR_TONE, 8'h09);
    `CHK("osc sel", 2'b01, {second_tone_oscillator_o, first_tone_oscillator_o})
    seen = 0;
    pulse_sync;
    for (int i = 0; i < 12 && seen == 0; i++) begin
      @(negedge clk_i) seen = int'(output_valid_o === 1'b1);
    end
    if (seen == 0) begin
      $display("ERROR tone valid expected 1 seen 0");
      n_mismatch++;
      test_done;
    end
    // amplitude 0x18c on y(0)=1.0 (0x4000) gives 0xc60, halved by the two-tone sum
    `CHK("tone sample", 16'sh0630, output_sample_o)
    wr(TGP_ADDR_TONE, 8'h0a);
    `CHK("osc sel", 2'b10, {second_tone_oscillator_o, first_tone_oscillator_o})
    wr(TGP_ADDR_TONE, 8'h00);
    `CHK("decoder on", 1'b1, decoder_enable_o)
    $display("test tone done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_pump;
    t_pass;
    t_coef;
    t_tone;
    test_done;
  end
endmodule // tgp_tone_pump_ctrl_tb
